// [verif/llmc_plant.sv]
`timescale 1ns/1ps

module llmc_plant (
	input wire logic ref_clk,
	input wire logic [1:0] cause,
	output llmc_pkg::llmc_sense_t sense
);
	import llmc_pkg::*;

	llmc_sense_t nxt;

	// ==========================================================
	// sensor side: 0 quiet standby, 1 fan fault, 2 pre-purge flame,
	// 3 quiet post-purge
	always_comb begin
		nxt = '0;
		nxt.phase = PH_STANDBY;
		nxt.fan_fault = (cause == 2'd1);
		if (cause == 2'd2) begin
			nxt.phase = PH_PREPURGE;
			nxt.flame = 1'b1;
		end
		if (cause == 2'd3) begin
			nxt.phase = PH_POSTPURGE;
		end
	end

	always @(posedge ref_clk) begin
		sense <= nxt;
	end
endmodule : llmc_plant

// [verif/testbench.sv]
`timescale 1ns/1ps
`include "llmc_defines.svh"

module testbench;
	import llmc_pkg::*;
	localparam int HS = 10;
	localparam int SEC = 2 * HS;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic button = 1'b0;
	logic [1:0] cause = 2'd0;
	llmc_sense_t sense;
	llmc_apb_req_t apb_req = '0;
	llmc_apb_rsp_t apb_rsp;
	logic led_green, led_red, lockout, recycle;
	llmc_act_t act;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	int g_rise = 0;
	int r_rise = 0;
	int g0, r0, i, k, j;
	logic g_d = 1'b0;
	logic r_d = 1'b0;
	logic [31:0] q;
	logic e;

	llmc_plant u_llmc_plant (.ref_clk(ref_clk), .cause(cause),
		.sense(sense));
	llmc_top #(.HALF_SEC_CYC(HS)) u_llmc_top (.ref_clk(ref_clk),
		.nrst(nrst), .button(button), .sense(sense), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .led_green(led_green), .led_red(led_red),
		.lockout(lockout), .recycle(recycle), .act(act));

	// ==========================================================
	// clock, led edge counters, timeout
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		g_d <= led_green;
		r_d <= led_red;
		if (led_green === 1'b1 && g_d === 1'b0) g_rise <= g_rise + 1;
		if (led_red === 1'b1 && r_d === 1'b0) r_rise <= r_rise + 1;
		if (cyc == 40000) begin
			n_fail++;
			report_and_stop;
		end
	end

	// ==========================================================
	// tasks
	task chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		total_checks++;
		if (got !== ex) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, ex, got);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= w;
		apb_req.paddr <= a;
		apb_req.pwdata <= d;
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		@(posedge ref_clk);
		while (apb_rsp.pready !== 1'b1) @(posedge ref_clk);
		q = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb

	// press n cycles, then stay released one second
	task btn(input int n);
		@(posedge ref_clk);
		button <= 1'b1;
		repeat (n) @(posedge ref_clk);
		button <= 1'b0;
		repeat (SEC) @(posedge ref_clk);
	endtask : btn

	task wait_lock(input logic v);
		for (k = 0; k < 2 * SEC && lockout !== v; k++) @(posedge ref_clk);
	endtask : wait_lock

	task clear_lock;
		cause <= 2'd0;
		q = '0;
		for (i = 0; i < 200 && q[1] !== 1'b1; i++)
			apb(1'b0, `LLMC_REG_STATUS, 32'h0);
		chk("shown", 1, q[1]);
		btn(SEC);
		chk("cleared", 0, lockout);
	endtask : clear_lock

	task report_and_stop;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// scenarios
	initial begin
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		chk("outs", 0, {led_green, led_red, lockout, recycle, act});
		apb(1'b0, `LLMC_REG_STATUS, 32'h0);
		chk("status", 0, q);
		apb(1'b0, 8'hF0, 32'h0);
		chk("bad data", 32'h0, q);
		chk("bad err", 32'h1, {31'h0, e});
		cause <= 2'd2;
		repeat (5) @(posedge ref_clk);
		chk("early lock", 0, lockout);
		wait_lock(1'b1);
		chk("pre flame lock", 1, lockout);
		apb(1'b0, `LLMC_REG_STATUS, 32'h0);
		chk("lk pre", LK_FLAME_PRE, q[5:2]);
		clear_lock;
		cause <= 2'd1;
		repeat (2) @(posedge ref_clk);
		chk("fan wait", 0, lockout);
		@(posedge ref_clk);
		chk("fan lock", 1, lockout);
		apb(1'b1, `LLMC_REG_LOG, 32'h0);
		apb(1'b0, `LLMC_REG_LOG, 32'h0);
		chk("log 0", {1'b1, LK_FAN, 4'h0}, q[8:0]);
		apb(1'b1, `LLMC_REG_LOG, 32'h1);
		apb(1'b0, `LLMC_REG_LOG, 32'h0);
		chk("log 1", {1'b1, LK_FLAME_PRE, 4'h1}, q[8:0]);
		clear_lock;
		@(posedge ref_clk);
		button <= 1'b1;
		g0 = g_rise;
		repeat (690) @(posedge ref_clk);
		chk("no blink", 0, g_rise - g0);
		repeat (25) @(posedge ref_clk);
		chk("six first", 1, g_rise - g0);
		button <= 1'b0;
		r0 = r_rise;
		repeat (SEC / 2) @(posedge ref_clk);
		apb(1'b0, `LLMC_REG_STATUS, 32'h0);
		chk("show", M_SHOW, q[8:6]);
		repeat (7 * SEC) @(posedge ref_clk);
		chk("red type", LK_FAN, r_rise - r0);
		btn(SEC);
		repeat (5 * SEC) @(posedge ref_clk);
		apb(1'b0, `LLMC_REG_STATUS, 32'h0);
		chk("extended", M_SHOW, q[8:6]);
		repeat (5 * SEC) @(posedge ref_clk);
		apb(1'b0, `LLMC_REG_STATUS, 32'h0);
		chk("page end", M_IDLE, q[8:6]);
		@(posedge ref_clk);
		button <= 1'b1;
		repeat (36 * SEC) @(posedge ref_clk);
		cause <= 2'd3;
		repeat (SEC) @(posedge ref_clk);
		button <= 1'b0;
		repeat (SEC) @(posedge ref_clk);
		apb(1'b0, `LLMC_REG_STATUS, 32'h0);
		chk("refused", M_IDLE, q[8:6]);
		cause <= 2'd0;
		repeat (SEC) @(posedge ref_clk);
		for (i = 1; i <= 5; i++) begin
			btn(41 * SEC);
			chk("green off", 0, led_green);
			for (k = 0; k < i; k++) begin
				@(posedge ref_clk);
				button <= 1'b1;
				repeat (SEC) @(posedge ref_clk);
				chk("green on", 1, led_green);
				button <= 1'b0;
				repeat (SEC) @(posedge ref_clk);
				chk("green rel", 0, led_green);
			end
			g0 = g_rise;
			for (k = 0; k < 30 * SEC && act === 5'h0; k++)
				@(posedge ref_clk);
			chk("act", 5'h10 >> (i - 1), act);
			chk("echo", i, g_rise - g0);
			chk("act late", 1, k >= (8 + i) * SEC);
			repeat (SEC) @(posedge ref_clk);
		end
		apb(1'b1, `LLMC_REG_LOG, 32'h0);
		apb(1'b0, `LLMC_REG_LOG, 32'h0);
		chk("log cleared", 0, q[8]);
		for (j = 0; j < 11; j++) begin
			cause <= j[0] ? 2'd2 : 2'd1;
			wait_lock(1'b1);
			clear_lock;
		end
		apb(1'b1, `LLMC_REG_LOG, 32'h9);
		apb(1'b0, `LLMC_REG_LOG, 32'h0);
		chk("log oldest", {1'b1, LK_FLAME_PRE, 4'h9}, q[8:0]);
		apb(1'b1, `LLMC_REG_LOG, 32'hA);
		apb(1'b0, `LLMC_REG_LOG, 32'h0);
		chk("log depth", 9'h00A, q[8:0]);
		apb(1'b0, `LLMC_REG_COUNT, 32'h0);
		chk("counts", 32'h0000000B, q);
		report_and_stop;
	end
endmodule : testbench

// [verilog/llmc_blink.sv]
`timescale 1ns/1ps
`include "llmc_defines.svh"

module llmc_blink (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic start,
	input wire llmc_pkg::llmc_cnt_t count,
	output logic led,
	output logic busy
);
	import llmc_pkg::*;

	llmc_blink_st_t s_r;
	llmc_blink_st_t s_nxt;

	// ======================================================================
	// half-second on, half-second off, count times
	always_comb begin
		s_nxt = s_r;
		if (start) begin
			s_nxt.rem = count;
			s_nxt.on = 1'b0;
			s_nxt.busy = (count != 4'h0);
		end else if (s_r.busy && tick) begin
			if (!s_r.on) begin
				s_nxt.on = 1'b1;
			end else begin
				s_nxt.on = 1'b0;
				s_nxt.rem = s_r.rem - 4'h1;
				s_nxt.busy = (s_r.rem != 4'h1);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign led = s_r.on;
	assign busy = s_r.busy;

endmodule : llmc_blink

// [verilog/llmc_defines.svh]
`ifndef LLMC_DEFINES_SVH
`define LLMC_DEFINES_SVH

// ==========================================================================
// clock and time base
`define LLMC_CLK_PERIOD_NS 5
`define LLMC_HALF_SEC_NS 500000000
`define LLMC_HALVES(s) ((s) * 2)

// ==========================================================================
// menu timing, seconds
`define LLMC_T_LOG_MIN_S 35
`define LLMC_T_RST_MIN_S 40
`define LLMC_T_RST_MAX_S 45
`define LLMC_T_PRESENT_S 10
`define LLMC_T_SEL_IDLE_S 10
`define LLMC_T_CODE_GAP_S 2

// ==========================================================================
// lockout timing, seconds
`define LLMC_T_PAR_STBY_S 25
`define LLMC_T_PAR_PRE_S 1
`define LLMC_T_SAFETY_S 3
`define LLMC_T_AIR_CLOSE_S 15
`define LLMC_T_AIR_LOSS_S 1
`define LLMC_T_AIR_STUCK_S 120

// ==========================================================================
// counts
`define LLMC_MAX_RECYCLES 3
`define LLMC_LOG_DEPTH 10
`define LLMC_LOG_BLINKS 6
`define LLMC_RST_BLINKS 7
`define LLMC_MAX_SEL 5

// ==========================================================================
// register map, byte addresses
`define LLMC_REG_STATUS 8'h00
`define LLMC_REG_LOG 8'h04
`define LLMC_REG_COUNT 8'h08

`endif

// [verilog/llmc_log.sv]
`timescale 1ns/1ps
`include "llmc_defines.svh"

module llmc_log (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic wr,
	input wire llmc_pkg::llmc_lk_t wr_type,
	input wire logic clr,
	input wire llmc_pkg::llmc_cnt_t rd_idx,
	output llmc_pkg::llmc_lk_t rd_type,
	output logic rd_valid,
	output llmc_pkg::llmc_lk_t newest
);
	import llmc_pkg::*;

	llmc_log_st_t s_r;
	llmc_log_st_t s_nxt;
	logic [4:0] pos;
	logic [4:0] npos;

	// ======================================================================
	// ring of lockouts, index 0 is the newest
	always_comb begin
		s_nxt = s_r;
		pos = 5'(s_r.wptr) + 5'(`LLMC_LOG_DEPTH - 1) - 5'(rd_idx);
		if (pos >= 5'(`LLMC_LOG_DEPTH)) begin
			pos = pos - 5'(`LLMC_LOG_DEPTH);
		end
		npos = 5'(s_r.wptr) + 5'(`LLMC_LOG_DEPTH - 1);
		if (npos >= 5'(`LLMC_LOG_DEPTH)) begin
			npos = npos - 5'(`LLMC_LOG_DEPTH);
		end
		s_nxt.rd_valid = (rd_idx < s_r.cnt);
		s_nxt.rd_type = s_nxt.rd_valid ? llmc_lk_t'(s_r.ent[pos[3:0]]) : LK_NONE;
		s_nxt.newest = (s_r.cnt != 4'h0) ? llmc_lk_t'(s_r.ent[npos[3:0]])
			: LK_NONE;
		if (clr) begin
			s_nxt.cnt = 4'h0;
			s_nxt.wptr = 4'h0;
		end
		if (wr) begin
			// newest overwrites oldest
			s_nxt.ent[s_nxt.wptr] = wr_type;
			s_nxt.wptr = (s_nxt.wptr == 4'(`LLMC_LOG_DEPTH - 1)) ? 4'h0
				: s_nxt.wptr + 4'h1;
			if (s_nxt.cnt != 4'(`LLMC_LOG_DEPTH)) begin
				s_nxt.cnt = s_nxt.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_type = s_r.rd_type;
	assign rd_valid = s_r.rd_valid;
	assign newest = s_r.newest;

	// ======================================================================
	// checks
	property p_log_depth;
		@(posedge ref_clk) disable iff (!nrst)
		s_r.cnt <= 4'(`LLMC_LOG_DEPTH);
	endproperty
	a_log_depth: assert property (p_log_depth)
		else $error("log holds more than ten entries");

	property p_log_wrap;
		@(posedge ref_clk) disable iff (!nrst)
		(wr && !clr && s_r.wptr == 4'(`LLMC_LOG_DEPTH - 1)) |=>
			(s_r.wptr == 4'h0) ##1 (s_r.newest == $past(wr_type, 2));
	endproperty
	a_log_wrap: assert property (p_log_wrap)
		else $error("ring pointer did not wrap to the oldest slot");

endmodule : llmc_log

// [verilog/llmc_pkg.sv]
`include "llmc_defines.svh"

package llmc_pkg;

	typedef logic [8:0] llmc_tmr_t;
	typedef logic [3:0] llmc_cnt_t;

	typedef enum logic [3:0] {
		LK_NONE, LK_FLAME_STBY, LK_FLAME_PRE, LK_NO_FLAME, LK_FLAME_LOSS,
		LK_FAN, LK_VALVE, LK_NVM, LK_AIR_NOCLOSE, LK_AIR_LOSS, LK_AIR_STUCK
	} llmc_lk_t;

	typedef enum logic [2:0] {
		PH_STANDBY, PH_PREPURGE, PH_LATE_PRE, PH_SAFETY, PH_RUN, PH_POSTPURGE
	} llmc_phase_t;

	typedef enum logic [2:0] {
		M_IDLE, M_HOLD, M_SHOW, M_COUNT, M_ECHO
	} llmc_menu_t;

	typedef enum logic [1:0] {AW_IDLE, AW_OPEN, AW_STUCK} llmc_aw_t;

	typedef struct packed {
		logic flame;
		logic air_ok;
		logic gas_valve;
		logic heat_req;
		logic fan_fault;
		logic valve_fault;
		logic nvm_fault;
		llmc_phase_t phase;
	} llmc_sense_t;

	typedef struct packed {
		logic clr_log;
		logic clr_lock_cnt;
		logic clr_hours;
		logic clr_heat_cnt;
		logic restore_def;
	} llmc_act_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} llmc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} llmc_apb_rsp_t;

	typedef struct packed {
		llmc_cnt_t rem;
		logic on;
		logic busy;
	} llmc_blink_st_t;

	typedef struct packed {
		logic [`LLMC_LOG_DEPTH-1:0][3:0] ent;
		llmc_cnt_t wptr;
		llmc_cnt_t cnt;
		llmc_lk_t rd_type;
		logic rd_valid;
		llmc_lk_t newest;
	} llmc_log_st_t;

endpackage : llmc_pkg

// [verilog/llmc_top.sv]
`timescale 1ns/1ps
`include "llmc_defines.svh"

module llmc_top #(
	parameter int unsigned HALF_SEC_CYC = `LLMC_HALF_SEC_NS / `LLMC_CLK_PERIOD_NS
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic button,
	input wire llmc_pkg::llmc_sense_t sense,
	input wire llmc_pkg::llmc_apb_req_t apb_req,
	output llmc_pkg::llmc_apb_rsp_t apb_rsp,
	output logic led_green,
	output logic led_red,
	output logic lockout,
	output logic recycle,
	output llmc_pkg::llmc_act_t act
);
	import llmc_pkg::*;

	typedef struct packed {
		logic [26:0] pre;
		logic tick;
		logic btn_d;
		logic heat_d;
		logic flame_d;
		llmc_menu_t menu;
		llmc_tmr_t hold;
		llmc_tmr_t mtmr;
		llmc_cnt_t sel;
		logic locked;
		logic shown;
		llmc_lk_t lk;
		llmc_tmr_t par_tmr;
		llmc_tmr_t ign_tmr;
		llmc_tmr_t loss_tmr;
		llmc_tmr_t aw_tmr;
		llmc_aw_t aw;
		logic [1:0] rcy;
		llmc_tmr_t gap;
		logic led_g;
		logic recycle;
		llmc_act_t act;
		logic [15:0] lock_cnt;
		logic [15:0] heat_cnt;
		llmc_cnt_t log_idx;
		logic [31:0] prdata;
		logic pslverr;
	} llmc_top_st_t;

	llmc_top_st_t s_r;
	llmc_top_st_t s_nxt;

	logic press;
	logic release_ev;
	logic allowed;
	logic log_win;
	logic rst_win;
	llmc_lk_t lk_ev;
	logic g_start;
	logic r_start;
	llmc_cnt_t g_cnt;
	llmc_cnt_t r_cnt;
	logic g_led;
	logic g_busy;
	logic r_led;
	logic r_busy;
	logic log_wr;
	logic log_clr;
	llmc_lk_t log_type;
	logic log_valid;
	llmc_lk_t log_newest;

	llmc_blink u_green (
		.ref_clk(ref_clk), .nrst(nrst), .tick(s_r.tick), .start(g_start),
		.count(g_cnt), .led(g_led), .busy(g_busy)
	);

	llmc_blink u_red (
		.ref_clk(ref_clk), .nrst(nrst), .tick(s_r.tick), .start(r_start),
		.count(r_cnt), .led(r_led), .busy(r_busy)
	);

	llmc_log u_log (
		.ref_clk(ref_clk), .nrst(nrst), .wr(log_wr), .wr_type(s_nxt.lk),
		.clr(log_clr), .rd_idx(s_r.log_idx), .rd_type(log_type),
		.rd_valid(log_valid), .newest(log_newest)
	);

	// ======================================================================
	// events and windows
	assign press = button && !s_r.btn_d;
	assign release_ev = !button && s_r.btn_d;
	assign allowed = (sense.phase == PH_STANDBY) || (sense.phase == PH_RUN);
	assign log_win = (s_r.hold >= llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_LOG_MIN_S)))
		&& (s_r.hold < llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_RST_MIN_S)));
	assign rst_win = (s_r.hold >= llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_RST_MIN_S)))
		&& (s_r.hold < llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_RST_MAX_S)));

	// ======================================================================
	// fault classification, highest priority first
	always_comb begin
		lk_ev = LK_NONE;
		if (sense.fan_fault) begin
			lk_ev = LK_FAN;
		end else if (sense.valve_fault) begin
			lk_ev = LK_VALVE;
		end else if (sense.nvm_fault) begin
			lk_ev = LK_NVM;
		end else if (s_r.par_tmr == llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_PAR_STBY_S))
			&& sense.phase != PH_PREPURGE) begin
			lk_ev = LK_FLAME_STBY;
		end else if (s_r.par_tmr >= llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_PAR_PRE_S))
			&& sense.phase == PH_PREPURGE) begin
			lk_ev = LK_FLAME_PRE;
		end else if (s_r.ign_tmr == llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_SAFETY_S))) begin
			lk_ev = LK_NO_FLAME;
		end else if (s_r.recycle
			&& s_r.rcy == 2'(`LLMC_MAX_RECYCLES)) begin
			lk_ev = LK_FLAME_LOSS;
		end else if (s_r.loss_tmr == llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_AIR_LOSS_S))) begin
			lk_ev = LK_AIR_LOSS;
		end else if (s_r.aw == AW_OPEN && s_r.aw_tmr
			== llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_AIR_CLOSE_S))) begin
			lk_ev = LK_AIR_NOCLOSE;
		end else if (s_r.aw == AW_STUCK && s_r.aw_tmr
			== llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_AIR_STUCK_S))) begin
			lk_ev = LK_AIR_STUCK;
		end
	end

	// ======================================================================
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.btn_d = button;
		s_nxt.heat_d = sense.heat_req;
		s_nxt.flame_d = sense.flame;
		s_nxt.tick = (s_r.pre == 27'(HALF_SEC_CYC - 1));
		s_nxt.pre = s_nxt.tick ? 27'h0 : s_r.pre + 27'h1;
		s_nxt.recycle = 1'b0;
		s_nxt.act = '0;
		g_start = 1'b0;
		g_cnt = 4'h0;
		r_start = 1'b0;
		r_cnt = 4'h0;
		log_wr = 1'b0;
		log_clr = 1'b0;

		// supervision timers, half-second resolution
		if (sense.flame && (sense.phase == PH_STANDBY
			|| sense.phase == PH_POSTPURGE || sense.phase == PH_PREPURGE)) begin
			if (s_r.tick) s_nxt.par_tmr = s_r.par_tmr + 9'h1;
		end else begin
			s_nxt.par_tmr = 9'h0;
		end
		if (sense.gas_valve && !sense.flame && sense.phase == PH_SAFETY) begin
			if (s_r.tick) s_nxt.ign_tmr = s_r.ign_tmr + 9'h1;
		end else begin
			s_nxt.ign_tmr = 9'h0;
		end
		if (!sense.air_ok && (sense.phase == PH_LATE_PRE
			|| sense.phase == PH_SAFETY || sense.phase == PH_RUN)) begin
			if (s_r.tick) s_nxt.loss_tmr = s_r.loss_tmr + 9'h1;
		end else begin
			s_nxt.loss_tmr = 9'h0;
		end
		if (!sense.flame && s_r.flame_d && sense.phase == PH_RUN
			&& !s_r.locked) begin
			s_nxt.recycle = 1'b1;
			s_nxt.rcy = s_r.rcy + 2'h1;
		end
		// air switch watch after request or recycle
		if (s_r.tick) s_nxt.aw_tmr = s_r.aw_tmr + 9'h1;
		if ((sense.heat_req && !s_r.heat_d) || s_r.recycle) begin
			s_nxt.aw = sense.air_ok ? AW_STUCK : AW_OPEN;
			s_nxt.aw_tmr = 9'h0;
		end else if (s_r.aw == AW_OPEN && sense.air_ok) begin
			s_nxt.aw = AW_IDLE;
		end else if (s_r.aw == AW_STUCK && !sense.air_ok) begin
			s_nxt.aw = AW_OPEN;
			s_nxt.aw_tmr = 9'h0;
		end
		if (sense.heat_req && !s_r.heat_d) begin
			s_nxt.heat_cnt = s_r.heat_cnt + 16'h1;
		end

		// lockout code on the red led, repeating
		if (s_r.locked && !r_busy) begin
			if (s_r.tick) s_nxt.gap = s_r.gap + 9'h1;
			if (s_r.gap == llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_CODE_GAP_S))) begin
				r_start = 1'b1;
				r_cnt = s_r.lk;
				s_nxt.gap = 9'h0;
				s_nxt.shown = 1'b1;
			end
		end
		if (s_r.locked && s_r.shown && press) begin
			s_nxt.locked = 1'b0;
			s_nxt.rcy = 2'h0;
			s_nxt.aw = AW_IDLE;
		end
		// a new fault is latched only while unlocked, so a fault in the clearing cycle is not taken
		if (!s_r.locked && lk_ev != LK_NONE) begin
			s_nxt.locked = 1'b1;
			s_nxt.shown = 1'b0;
			s_nxt.gap = 9'h0;
			s_nxt.lk = lk_ev;
			s_nxt.lock_cnt = s_r.lock_cnt + 16'h1;
			log_wr = 1'b1;
		end

		// menu
		if (s_r.tick) s_nxt.mtmr = s_r.mtmr + 9'h1;
		case (s_r.menu)
			M_IDLE: begin
				if (press && !s_r.locked && allowed) begin
					s_nxt.menu = M_HOLD;
					s_nxt.hold = 9'h0;
				end
			end
			M_HOLD: begin
				if (s_r.tick && s_r.hold != 9'h1FF) begin
					s_nxt.hold = s_r.hold + 9'h1;
				end
				if (s_r.tick && s_r.hold
					== llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_LOG_MIN_S) - 1)) begin
					g_start = 1'b1;
					g_cnt = 4'(`LLMC_LOG_BLINKS);
				end
				if (s_r.tick && s_r.hold
					== llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_RST_MIN_S) - 1)) begin
					g_start = 1'b1;
					g_cnt = 4'(`LLMC_RST_BLINKS);
				end
				if (release_ev) begin
					s_nxt.mtmr = 9'h0;
					s_nxt.sel = 4'h0;
					s_nxt.menu = M_IDLE;
					if (!allowed) begin
						s_nxt.menu = M_IDLE;
					end else if (log_win) begin
						s_nxt.menu = M_SHOW;
						r_start = 1'b1;
						r_cnt = log_newest;
					end else if (rst_win) begin
						s_nxt.menu = M_COUNT;
						g_start = 1'b1;
						g_cnt = 4'h0;
					end
				end
			end
			M_SHOW: begin
				if (press) begin
					s_nxt.mtmr = 9'h0;
					r_start = 1'b1;
					r_cnt = log_newest;
				end else if (s_r.mtmr
					== llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_PRESENT_S))) begin
					s_nxt.menu = M_IDLE;
				end
			end
			M_COUNT: begin
				if (press) begin
					s_nxt.mtmr = 9'h0;
					if (s_r.sel != 4'hF) s_nxt.sel = s_r.sel + 4'h1;
				end else if (button) begin
					s_nxt.mtmr = 9'h0;
				end else if (s_r.mtmr
					== llmc_tmr_t'(`LLMC_HALVES(`LLMC_T_SEL_IDLE_S))) begin
					s_nxt.menu = (s_r.sel == 4'h0) ? M_IDLE : M_ECHO;
					g_start = 1'b1;
					g_cnt = s_r.sel;
				end
			end
			M_ECHO: begin
				if (!g_busy) begin
					s_nxt.menu = M_IDLE;
					case (s_r.sel)
						4'h1: begin
							s_nxt.act.clr_log = 1'b1;
							log_clr = 1'b1;
						end
						4'h2: begin
							s_nxt.act.clr_lock_cnt = 1'b1;
							s_nxt.lock_cnt = 16'h0;
						end
						4'h3: s_nxt.act.clr_hours = 1'b1;
						4'h4: begin
							s_nxt.act.clr_heat_cnt = 1'b1;
							s_nxt.heat_cnt = 16'h0;
						end
						4'(`LLMC_MAX_SEL): s_nxt.act.restore_def = 1'b1;
						default: s_nxt.act = '0;
					endcase
				end
			end
			default: s_nxt.menu = M_IDLE;
		endcase
		if (!s_r.locked && lk_ev != LK_NONE) s_nxt.menu = M_IDLE;
		s_nxt.led_g = (s_r.menu == M_COUNT) ? button : g_led;

		// register slave: read data taken in the setup cycle
		if (apb_req.psel && !apb_req.penable) begin
			s_nxt.pslverr = 1'b0;
			case (apb_req.paddr)
				`LLMC_REG_STATUS: s_nxt.prdata = {21'h0, s_r.rcy,
					s_r.menu, s_r.lk, s_r.shown, s_r.locked};
				`LLMC_REG_LOG: s_nxt.prdata = {23'h0, log_valid, log_type,
					s_r.log_idx};
				`LLMC_REG_COUNT: s_nxt.prdata = {s_r.heat_cnt, s_r.lock_cnt};
				default: begin
					s_nxt.prdata = 32'h0;
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_req.psel && apb_req.penable && apb_req.pwrite
			&& apb_req.paddr == `LLMC_REG_LOG) begin
			s_nxt.log_idx = apb_req.pwdata[3:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apb_rsp = {s_r.prdata, 1'b1,
		s_r.pslverr && apb_req.psel && apb_req.penable};
	assign led_green = s_r.led_g;
	assign led_red = r_led;
	assign lockout = s_r.locked;
	assign recycle = s_r.recycle;
	assign act = s_r.act;

	// ======================================================================
	// checks
	sequence s_release_in(logic win);
		s_r.menu == M_HOLD && release_ev && allowed && win
			&& lk_ev == LK_NONE;
	endsequence

	property p_gate;
		@(posedge ref_clk) disable iff (!nrst)
		(s_r.menu == M_HOLD && release_ev && !allowed) |=> s_r.menu == M_IDLE;
	endproperty
	a_gate: assert property (p_gate)
		else $error("page entered outside standby or operating");

	property p_log_page;
		@(posedge ref_clk) disable iff (!nrst)
		s_release_in(log_win) |=> s_r.menu == M_SHOW && s_r.mtmr == 9'h0;
	endproperty
	a_log_page: assert property (p_log_page)
		else $error("display window did not open the display page");

	property p_six;
		@(posedge ref_clk) disable iff (!nrst)
		(s_r.menu == M_HOLD && !release_ev && s_r.tick && s_r.hold == 9'd69)
			|=> ##[1:2] g_busy;
	endproperty
	a_six: assert property (p_six)
		else $error("no confirm pulses at the display window");

	property p_show_len;
		@(posedge ref_clk) disable iff (!nrst)
		s_r.menu == M_SHOW |-> s_r.mtmr <= 9'd20;
	endproperty
	a_show_len: assert property (p_show_len)
		else $error("presentation ran past ten seconds");

	property p_restart;
		@(posedge ref_clk) disable iff (!nrst)
		(s_r.menu == M_SHOW && press && lk_ev == LK_NONE) |=>
			s_r.menu == M_SHOW && s_r.mtmr == 9'h0;
	endproperty
	a_restart: assert property (p_restart)
		else $error("press did not restart the presentation");

	property p_rst_page;
		@(posedge ref_clk) disable iff (!nrst)
		s_release_in(rst_win) |=> s_r.menu == M_COUNT && s_r.sel == 4'h0;
	endproperty
	a_rst_page: assert property (p_rst_page)
		else $error("reset window did not open the reset page");

	property p_follow;
		@(posedge ref_clk) disable iff (!nrst)
		(s_r.menu == M_COUNT && $rose(button)) |=> ##1 led_green;
	endproperty
	a_follow: assert property (p_follow)
		else $error("green did not follow the press");

	property p_third;
		@(posedge ref_clk) disable iff (!nrst)
		(!s_r.locked && s_r.recycle && s_r.rcy == 2'd3 && !sense.fan_fault
			&& !sense.valve_fault && !sense.nvm_fault && s_r.par_tmr == 9'h0
			&& s_r.ign_tmr == 9'h0) |=> lockout && s_r.lk == LK_FLAME_LOSS;
	endproperty
	a_third: assert property (p_third)
		else $error("third recycle did not lock out");

	property p_immediate;
		@(posedge ref_clk) disable iff (!nrst)
		(!s_r.locked && sense.fan_fault) |=> lockout && s_r.lk == LK_FAN;
	endproperty
	a_immediate: assert property (p_immediate)
		else $error("fan fault did not lock out at once");

	property p_hold_lock;
		@(posedge ref_clk) disable iff (!nrst)
		(s_r.locked && !s_r.shown && !r_start) |=> lockout;
	endproperty
	a_hold_lock: assert property (p_hold_lock)
		else $error("lockout cleared before its code was shown");

endmodule : llmc_top
